//--- hdl/msb_pkg.sv
// constants and types for the multiplexed strobe bus port
// assumes a single 10 MHz clock domain
package msb_pkg;
	localparam int BUS_W = 8;
	localparam int SYNC_STAGES = 2;
	localparam logic [BUS_W-1:0] ADDR_RST = 8'h00;
	localparam logic [BUS_W-1:0] DATA_RST = 8'h00;
	typedef logic [BUS_W-1:0] msb_byte_t;
	typedef enum logic [2:0] {
		MSB_IDLE = 3'b001,
		MSB_WRITE = 3'b010,
		MSB_READ = 3'b100
	} msb_state_t;
endpackage : msb_pkg

//--- hdl/msb_sync.sv
// two-flop synchroniser for a group of pin levels
// assumes inputs are asynchronous to ref_clk
`timescale 1ns/1ns
module msb_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_q;
	// first stage feeds only the second stage
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			meta_q <= RST_VAL;
			q <= RST_VAL;
		end else begin
			meta_q <= d;
			q <= meta_q;
		end
	end
endmodule : msb_sync

//--- hdl/msb_port.sv
// muxed address/data strobe port facing the host bus
// assumes host drives all strobes; core register file sits on the user side
`timescale 1ns/1ns
module msb_port
	import msb_pkg::*;
#(
	parameter int BW = BUS_W
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [BW-1:0] muxed_bus_i,
	output logic [BW-1:0] muxed_bus_o,
	output logic muxed_bus_oe,
	input wire logic ale,
	input wire logic cs_n,
	input wire logic wr_n,
	input wire logic rd_n,
	output logic [BW-1:0] reg_addr,
	output logic reg_wr,
	output logic [BW-1:0] reg_wdata,
	output logic reg_rd,
	input wire logic [BW-1:0] reg_rdata
);
	// ============================================================
	// synchronisers
	localparam int SW = BW + 4;
	logic [SW-1:0] raw;
	logic [SW-1:0] syn;
	logic [BW-1:0] bus_s;
	logic ale_s;
	logic cs_n_s;
	logic wr_n_s;
	logic rd_n_s;
	assign raw = {muxed_bus_i, ale, cs_n, wr_n, rd_n};
	// strobes idle inactive so reset does not fake an edge
	msb_sync #(.W(SW), .RST_VAL({{BW{1'b0}}, 4'h7})) u_sync (
		.ref_clk(ref_clk),
		.rst(rst),
		.d(raw),
		.q(syn)
	);
	assign {bus_s, ale_s, cs_n_s, wr_n_s, rd_n_s} = syn;

	// ============================================================
	// edge detection on synchronised strobes
	logic ale_q;
	logic wr_n_q;
	logic [BW-1:0] bus_q;
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			ale_q <= 1'b0;
			wr_n_q <= 1'b1;
			bus_q <= DATA_RST;
		end else begin
			ale_q <= ale_s;
			wr_n_q <= wr_n_s;
			bus_q <= bus_s;
		end
	end
	logic ale_fall;
	logic wr_rise;
	logic rd_act;
	logic wr_act;
	assign ale_fall = ale_q & ~ale_s;
	// data sampled at the end of the strobe, when it must be stable
	assign wr_rise = ~wr_n_q & wr_n_s;
	// a strobe counts only while chip select is low
	function automatic logic strobe_on(input logic strobe_n, input logic sel_n);
		return ~strobe_n & ~sel_n;
	endfunction : strobe_on
	assign rd_act = strobe_on(rd_n_s, cs_n_s);
	assign wr_act = strobe_on(wr_n_s, cs_n_s);

	// ============================================================
	// address latch
	logic [BW-1:0] addr_q;
	// latches regardless of chip select; uses bus value from before the fall
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			addr_q <= ADDR_RST;
		end else if (ale_fall) begin
			addr_q <= bus_q;
		end
	end
	assign reg_addr = addr_q;

	// ============================================================
	// cycle state
	msb_state_t state_q;
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state_q <= MSB_IDLE;
		end else begin
			case (state_q)
				MSB_IDLE: begin
					if (rd_act) begin
						state_q <= MSB_READ;
					end else if (wr_act) begin
						state_q <= MSB_WRITE;
					end
				end
				MSB_WRITE: begin
					if (wr_n_s) begin
						state_q <= MSB_IDLE;
					end
				end
				MSB_READ: begin
					if (rd_n_s | cs_n_s) begin
						state_q <= MSB_IDLE;
					end
				end
				default: begin
					state_q <= MSB_IDLE;
				end
			endcase
		end
	end

	// ============================================================
	// write path: one pulse per strobe, only if chip select is still low when the strobe ends
	logic wr_q;
	logic [BW-1:0] wdata_q;
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			wr_q <= 1'b0;
			wdata_q <= DATA_RST;
		end else begin
			wr_q <= (state_q == MSB_WRITE) & wr_rise & ~cs_n_s;
			if ((state_q == MSB_WRITE) & ~wr_n_s) begin
				wdata_q <= bus_s;
			end
		end
	end
	assign reg_wr = wr_q;
	assign reg_wdata = wdata_q;

	// ============================================================
	// read path
	logic oe_q;
	logic rd_q;
	logic [BW-1:0] rdata_q;
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			oe_q <= 1'b0;
			rd_q <= 1'b0;
			rdata_q <= DATA_RST;
		end else begin
			oe_q <= rd_act;
			rd_q <= rd_act & (state_q == MSB_IDLE);
			if (rd_act) begin
				rdata_q <= reg_rdata;
			end
		end
	end
	assign muxed_bus_oe = oe_q;
	assign muxed_bus_o = rdata_q;
	assign reg_rd = rd_q;

	// ============================================================
	// checks
	AST_WR_NEEDS_CS: assert property (@(posedge ref_clk) disable iff (rst)
		reg_wr |-> $past(~cs_n_s) && $past(wr_rise))
		else $error("write pulse without chip select or strobe end");
	AST_ONE_WR: assert property (@(posedge ref_clk) disable iff (rst)
		reg_wr |=> !reg_wr)
		else $error("more than one write per strobe");
	AST_OE_FOLLOWS_RD: assert property (@(posedge ref_clk) disable iff (rst)
		muxed_bus_oe == $past(rd_act))
		else $error("drive enable not tied to read with chip select");
	AST_RELEASE: assert property (@(posedge ref_clk) disable iff (rst)
		rd_n_s |=> !muxed_bus_oe)
		else $error("bus still driven after read strobe rose");
	AST_ADDR_LATCH: assert property (@(posedge ref_clk) disable iff (rst)
		ale_fall |=> reg_addr == $past(bus_q))
		else $error("address not latched on strobe fall");
	AST_ADDR_HOLD: assert property (@(posedge ref_clk) disable iff (rst)
		!ale_fall |=> $stable(reg_addr))
		else $error("address changed without strobe fall");
	AST_NO_CS_NO_OE: assert property (@(posedge ref_clk) disable iff (rst)
		$past(cs_n_s) |-> !muxed_bus_oe)
		else $error("bus driven without chip select");
	AST_WDATA: assert property (@(posedge ref_clk) disable iff (rst)
		reg_wr |-> reg_wdata == $past(bus_s, 2))
		else $error("write data not last strobe sample");
	AST_RD_WITH_OE: assert property (@(posedge ref_clk) disable iff (rst)
		reg_rd |-> muxed_bus_oe)
		else $error("read start pulse without bus drive");
	AST_NO_WR_IN_READ: assert property (@(posedge ref_clk) disable iff (rst)
		(state_q == MSB_READ) |-> !reg_wr)
		else $error("write pulse during a read cycle");
	AST_STATE_ONEHOT: assert property (@(posedge ref_clk) disable iff (rst)
		$onehot(state_q))
		else $error("cycle state not one-hot");

	// ============================================================
	// write count helper
	// writes since the strobe last fell; a slow release must not count twice
	logic [1:0] wr_cnt_q;
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			wr_cnt_q <= 2'h0;
		end else if (wr_n_q & ~wr_n_s) begin
			wr_cnt_q <= 2'h0;
		end else if (reg_wr & ~&wr_cnt_q) begin
			wr_cnt_q <= wr_cnt_q + 2'h1;
		end
	end
	AST_WR_PER_PULSE: assert property (@(posedge ref_clk) disable iff (rst)
		wr_cnt_q <= 2'h1)
		else $error("second write within one strobe pulse");
endmodule : msb_port

//--- bench/msb_host.sv
// host model driving the strobe pins and the shared bus
// assumes tasks are entered at a falling edge of ref_clk
`timescale 1ns/1ns
module msb_host (
	input wire logic ref_clk,
	output logic ale,
	output logic cs_n,
	output logic wr_n,
	output logic rd_n,
	output logic [7:0] bus
);
	initial begin
		{ale, cs_n, wr_n, rd_n, bus} = 12'h700;
	end
	task automatic gap(input int n);
		repeat (n) @(negedge ref_clk);
	endtask : gap
	// ==========================================
	// one bus cycle: address phase then data phase
	task automatic acc(input logic [7:0] a, input logic [7:0] d, input logic cs, input logic wr);
		ale = 1'b1;
		bus = a;
		gap(5);
		ale = 1'b0;
		gap(4);
		// released bus shows the inverse, not the old value
		bus = wr ? d : ~a;
		cs_n = ~cs;
		wr_n = ~wr;
		rd_n = wr;
		gap(7);
		{wr_n, rd_n} = 2'b11;
		gap(2);
		bus = ~bus;
		gap(3);
		cs_n = 1'b1;
		gap(6);
	endtask : acc
endmodule : msb_host

//--- bench/msb_port_tb.sv
// self-checking bench for msb_port with host model and core stub
// assumes core read data is a fixed function of the address
`timescale 1ns/1ns
module msb_port_tb;
	import msb_pkg::*;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic ale, cs_n, wr_n, rd_n, oe, reg_wr, reg_rd;
	msb_byte_t h_bus, bus_o, reg_addr, reg_wdata;
	logic [16:0] exp_q[$];
	logic [16:0] e;
	logic oe_q = 1'b0;
	int miscompares = 0;
	int n_checks = 0;
	logic [31:0] rs = 32'h7c72aaa1;
	always #50 ref_clk = ~ref_clk;
	msb_host u_msb_host (.ref_clk(ref_clk), .ale(ale), .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n), .bus(h_bus));
	msb_port u_msb_port (.ref_clk(ref_clk), .rst(rst), .muxed_bus_i(oe ? bus_o : h_bus), .muxed_bus_o(bus_o),
		.muxed_bus_oe(oe), .ale(ale), .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_addr ^ 8'h5a));
	function automatic logic [31:0] xs(input logic [31:0] v);
		v ^= v << 13;
		v ^= v >> 17;
		return v ^ (v << 5);
	endfunction : xs
	task automatic chk(input string n, input logic [16:0] x, input logic [16:0] s);
		n_checks++;
		if (s !== x) begin
			miscompares++;
			$display("MISMATCH %s exp %h got %h", n, x, s);
		end
	endtask : chk
	task automatic test_done;
		$display("checks %0d miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : test_done
	// ==========================================
	// watcher: a write pulse or a read start takes the oldest note
	always @(posedge ref_clk) begin
		oe_q <= oe;
		if (reg_wr === 1'b1 || reg_rd === 1'b1 || (oe === 1'b1 && oe_q !== 1'b1)) begin
			e = exp_q.size() ? exp_q.pop_front() : 17'h1ffff;
			chk("result", e, {oe, reg_addr, oe ? bus_o : reg_wdata});
			chk("read start", {16'h0, e[16]}, {16'h0, reg_rd});
		end
	end
	// ==========================================
	// main sequence
	initial begin
		logic [7:0] a, d;
		logic w, c;
		repeat (16) @(negedge ref_clk);
		rst = 1'b0;
		u_msb_host.gap(3);
		// every eighth cycle runs without chip select
		for (int i = 0; i < 40; i++) begin
			rs = xs(rs);
			{a, d, w} = rs[16:0];
			c = (i % 8) != 3;
			// deselected cycles alternate between write and read
			w = c ? w : i[3];
			if (c) begin
				exp_q.push_back({~w, a, w ? d : a ^ 8'h5a});
			end
			u_msb_host.acc(a, d, c, w);
			chk("addr", {9'h0, a}, {8'h0, oe, reg_addr});
		end
		chk("pending", 17'h0, 17'(exp_q.size()));
		$display("test random access done");
		test_done();
	end
endmodule : msb_port_tb
